// file: common/dafsl_pkg.sv
// Package of the diagnostic flag, alert and shunt limit block.
// Assumes one 25 MHz clock and a plain register port with 8-bit offsets.
package dafsl_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    localparam logic [ADDR_W-1:0] ADDR_DIAG  = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_OVTHR = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_UVTHR = 8'h0D;

    localparam int unsigned BIT_LATCH  = 15;
    localparam int unsigned BIT_RDYALT = 14;
    localparam int unsigned BIT_AVGCMP = 13;
    localparam int unsigned BIT_POLSEL = 12;
    localparam int unsigned BIT_ENOF   = 11;
    localparam int unsigned BIT_CHOF   = 10;
    localparam int unsigned BIT_ARITH  = 9;
    localparam int unsigned BIT_RSVD   = 8;
    localparam int unsigned BIT_TEMPOL = 7;
    localparam int unsigned BIT_SHOL   = 6;
    localparam int unsigned BIT_SHUL   = 5;
    localparam int unsigned BIT_BUSOVR = 4;
    localparam int unsigned BIT_BUSUND = 3;
    localparam int unsigned BIT_PWROL  = 2;
    localparam int unsigned BIT_RDY    = 1;
    localparam int unsigned BIT_TRIM   = 0;

    localparam logic [DATA_W-1:0] OVTHR_RST  = 16'h7FFF;
    localparam logic [DATA_W-1:0] UVTHR_RST  = 16'h8000;
    localparam logic [DATA_W-1:0] RDATA_NONE = 16'h0000;

    // Threshold LSB is 16 measurement LSBs for shunt and bus, 256 for power.
    localparam logic [3:0] SHUNT_THR_PAD = 4'h0;
    localparam logic [3:0] BUS_THR_PAD   = 4'h0;
    localparam logic [7:0] PWR_THR_PAD   = 8'h00;

    typedef struct packed {
        logic [19:0] shunt;
        logic [19:0] bus;
        logic [15:0] temp;
        logic [23:0] power;
    } dafsl_meas_t;

    typedef struct packed {
        logic [14:0] bus_over;
        logic [14:0] bus_under;
        logic [15:0] temp_over;
        logic [15:0] power_over;
    } dafsl_lim_t;

    typedef struct packed {
        logic conv_done;
        logic avg_done;
        logic conv_start;
        logic energy_ovf;
        logic charge_ovf;
        logic arith_ovf;
        logic energy_read;
        logic charge_read;
        logic accumulator_clear;
        logic trim_checksum_err;
    } dafsl_evt_t;

    typedef struct packed {
        logic alert_latch_enable;
        logic ready_on_alert_enable;
        logic averaged_compare_sel;
        logic alert_polarity_sel;
    } dafsl_cfg_t;

    typedef struct packed {
        logic energy_overflow_flag;
        logic charge_overflow_flag;
        logic arith_overflow_flag;
        logic temp_over_limit_flag;
        logic shunt_over_limit_flag;
        logic shunt_under_limit_flag;
        logic bus_over_limit_flag;
        logic bus_under_limit_flag;
        logic power_over_limit_flag;
        logic conv_ready_flag;
        logic trim_memory_ok;
    } dafsl_flags_t;

    typedef struct packed {
        dafsl_cfg_t        cfg;
        dafsl_flags_t      flags;
        logic [DATA_W-1:0] shunt_over_threshold;
        logic [DATA_W-1:0] shunt_under_threshold;
        logic [DATA_W-1:0] rdata;
        logic              alert_out;
        logic              alert_oe;
    } dafsl_state_t;

    localparam dafsl_state_t STATE_RST = '{
        cfg:                   '0,
        flags:                 '{trim_memory_ok: 1'b1, default: 1'b0},
        shunt_over_threshold:  OVTHR_RST,
        shunt_under_threshold: UVTHR_RST,
        rdata:                 RDATA_NONE,
        alert_out:             1'b0,
        alert_oe:              1'b0
    };

endpackage

// file: rtl/dafsl_diag.sv
// Diagnostic flags, alert pin control and shunt limit registers.
// Assumes measurements and event pulses arrive synchronous to ref_clk and
// that accumulator reads are decoded outside and reported as pulses.
//
// The implementer's own choice: strobed register access.

//Contract
// R1 - Polarity bit twelve selects low or high alert.
// R2 - Energy overflow sets flag, energy read clears.
// R3 - Charge overflow sets flag, charge read clears.
// R4 - Arithmetic overflow sets its flag.
// R5 - Arithmetic flag held until conversion or clear.
// R6 - Bit eight always reads zero.
// R7 - Temperature above its limit sets flag.
// R8 - Shunt above over threshold sets flag.
// R9 - Shunt below under threshold sets flag.
// R10 - Bus above over limit sets flag.
// R11 - Bus below under limit sets flag.
// R12 - Power above limit sets flag.
// R13 - Latched limit flags clear only on read.
// R14 - Conversion complete sets ready flag.
// R15 - Latched ready clears on read or start.
// R16 - Trim status resets high, drops on error.
// R17 - Negative over threshold trips at zero shunt.
// R18 - Host keeps over threshold above under threshold.
// R19 - Over threshold signed, scaled per range.
// R20 - Over threshold at 0xC, resets 0x7FFF.
// R21 - Under threshold at 0xD, resets 0x8000.
// R22 - Transparent follows fault, latched holds till read.
// R23 - Ready flag drives alert when enabled.
// R24 - Compare raw or averaged results.
// R25 - Any limit flag drives alert active.
// R26 - Under compare signed and consistently scaled.
module dafsl_diag
    import dafsl_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire dafsl_meas_t       meas,
    input  wire dafsl_lim_t        lim,
    input  wire dafsl_evt_t        evt,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   alert_out,
    output logic                   alert_oe
);

    dafsl_state_t s_q;
    dafsl_state_t s_d;

    logic        diag_rd;
    logic        sample;
    logic        temp_over;
    logic        shunt_over;
    logic        shunt_under;
    logic        bus_over;
    logic        bus_under;
    logic        power_over;
    logic        alert_active;
    logic signed [19:0] shunt_over_scaled;
    logic signed [19:0] shunt_under_scaled;
    logic signed [19:0] bus_over_scaled;
    logic signed [19:0] bus_under_scaled;
    logic        [23:0] power_scaled;

    function automatic logic [DATA_W-1:0] diag_word(input dafsl_state_t s);
        logic [DATA_W-1:0] w;
        w = '0;
        w[BIT_LATCH]  = s.cfg.alert_latch_enable;
        w[BIT_RDYALT] = s.cfg.ready_on_alert_enable;
        w[BIT_AVGCMP] = s.cfg.averaged_compare_sel;
        w[BIT_POLSEL] = s.cfg.alert_polarity_sel;
        w[BIT_ENOF]   = s.flags.energy_overflow_flag;
        w[BIT_CHOF]   = s.flags.charge_overflow_flag;
        w[BIT_ARITH]  = s.flags.arith_overflow_flag;
        w[BIT_RSVD]   = 1'b0; // [R6]
        w[BIT_TEMPOL] = s.flags.temp_over_limit_flag;
        w[BIT_SHOL]   = s.flags.shunt_over_limit_flag;
        w[BIT_SHUL]   = s.flags.shunt_under_limit_flag;
        w[BIT_BUSOVR] = s.flags.bus_over_limit_flag;
        w[BIT_BUSUND] = s.flags.bus_under_limit_flag;
        w[BIT_PWROL]  = s.flags.power_over_limit_flag;
        w[BIT_RDY]    = s.flags.conv_ready_flag;
        w[BIT_TRIM]   = s.flags.trim_memory_ok;
        return w;
    endfunction

    function automatic logic alert_cause(input dafsl_state_t s);
        logic c;
        c = s.flags.temp_over_limit_flag | s.flags.shunt_over_limit_flag
          | s.flags.shunt_under_limit_flag | s.flags.bus_over_limit_flag
          | s.flags.bus_under_limit_flag | s.flags.power_over_limit_flag;
        c = c | (s.cfg.ready_on_alert_enable & s.flags.conv_ready_flag);
        return c;
    endfunction

    // A threshold step is sixteen shunt LSBs in either shunt range, so the
    // same alignment serves both ranges and no range input is needed.
    always_comb begin
        shunt_over_scaled  = $signed({s_q.shunt_over_threshold,
                                      SHUNT_THR_PAD}); // [R19]
        shunt_under_scaled = $signed({s_q.shunt_under_threshold,
                                      SHUNT_THR_PAD}); // [R26]
        bus_over_scaled    = $signed({1'b0, lim.bus_over, BUS_THR_PAD});
        bus_under_scaled   = $signed({1'b0, lim.bus_under, BUS_THR_PAD});
        power_scaled       = {lim.power_over, PWR_THR_PAD};
    end

    always_comb begin
        temp_over   = $signed(meas.temp) > $signed(lim.temp_over); // [R7]
        // Signed compare: a negative threshold trips at zero shunt.
        shunt_over  = $signed(meas.shunt) > shunt_over_scaled; // [R8] [R17]
        shunt_under = $signed(meas.shunt) < shunt_under_scaled; // [R9] [R26]
        bus_over    = $signed(meas.bus) > bus_over_scaled; // [R10]
        bus_under   = $signed(meas.bus) < bus_under_scaled; // [R11]
        power_over  = meas.power > power_scaled; // [R12]
    end

    always_comb begin
        diag_rd = reg_rd && (reg_addr == ADDR_DIAG);
        sample  = s_q.cfg.averaged_compare_sel ? evt.avg_done
                                               : evt.conv_done; // [R24]
    end

    always_comb begin
        s_d       = s_q;
        s_d.rdata = RDATA_NONE;

        if (reg_rd) begin
            if (reg_addr == ADDR_DIAG) begin
                s_d.rdata = diag_word(s_q);
            end else if (reg_addr == ADDR_OVTHR) begin
                s_d.rdata = s_q.shunt_over_threshold;
            end else if (reg_addr == ADDR_UVTHR) begin
                s_d.rdata = s_q.shunt_under_threshold;
            end else begin
                s_d.rdata = RDATA_NONE;
            end
        end

        if (reg_wr) begin
            if (reg_addr == ADDR_DIAG) begin
                // Flag bits are not writable; only the mode bits store.
                s_d.cfg.alert_latch_enable    = reg_wdata[BIT_LATCH];
                s_d.cfg.ready_on_alert_enable = reg_wdata[BIT_RDYALT];
                s_d.cfg.averaged_compare_sel  = reg_wdata[BIT_AVGCMP];
                s_d.cfg.alert_polarity_sel    = reg_wdata[BIT_POLSEL]; // [R1]
            end else if (reg_addr == ADDR_OVTHR) begin
                s_d.shunt_over_threshold = reg_wdata; // [R20]
            end else if (reg_addr == ADDR_UVTHR) begin
                s_d.shunt_under_threshold = reg_wdata; // [R21]
            end
        end

        // Clears are applied first so that a same-cycle event still sets.
        if (evt.energy_read) begin
            s_d.flags.energy_overflow_flag = 1'b0; // [R2]
        end
        if (evt.energy_ovf) begin
            s_d.flags.energy_overflow_flag = 1'b1; // [R2]
        end
        if (evt.charge_read) begin
            s_d.flags.charge_overflow_flag = 1'b0; // [R3]
        end
        if (evt.charge_ovf) begin
            s_d.flags.charge_overflow_flag = 1'b1; // [R3]
        end
        if (evt.conv_start || evt.accumulator_clear) begin
            s_d.flags.arith_overflow_flag = 1'b0; // [R5]
        end
        if (evt.arith_ovf) begin
            s_d.flags.arith_overflow_flag = 1'b1; // [R4]
        end

        if (s_q.cfg.alert_latch_enable) begin
            if (diag_rd) begin
                s_d.flags.temp_over_limit_flag   = 1'b0; // [R13]
                s_d.flags.shunt_over_limit_flag  = 1'b0;
                s_d.flags.shunt_under_limit_flag = 1'b0;
                s_d.flags.bus_over_limit_flag    = 1'b0;
                s_d.flags.bus_under_limit_flag   = 1'b0;
                s_d.flags.power_over_limit_flag  = 1'b0;
            end
            if (sample) begin
                s_d.flags.temp_over_limit_flag =
                    s_d.flags.temp_over_limit_flag | temp_over; // [R22]
                s_d.flags.shunt_over_limit_flag =
                    s_d.flags.shunt_over_limit_flag | shunt_over;
                s_d.flags.shunt_under_limit_flag =
                    s_d.flags.shunt_under_limit_flag | shunt_under;
                s_d.flags.bus_over_limit_flag =
                    s_d.flags.bus_over_limit_flag | bus_over;
                s_d.flags.bus_under_limit_flag =
                    s_d.flags.bus_under_limit_flag | bus_under;
                s_d.flags.power_over_limit_flag =
                    s_d.flags.power_over_limit_flag | power_over;
            end
        end else if (sample) begin
            // Transparent flags follow the latest compared result.
            s_d.flags.temp_over_limit_flag   = temp_over; // [R22]
            s_d.flags.shunt_over_limit_flag  = shunt_over;
            s_d.flags.shunt_under_limit_flag = shunt_under;
            s_d.flags.bus_over_limit_flag    = bus_over;
            s_d.flags.bus_under_limit_flag   = bus_under;
            s_d.flags.power_over_limit_flag  = power_over;
        end

        // The ready flag is cleared the same way in both modes; in
        // transparent mode nothing else would ever drop it.
        if (diag_rd || evt.conv_start) begin
            s_d.flags.conv_ready_flag = 1'b0; // [R15]
        end
        if (evt.conv_done) begin
            s_d.flags.conv_ready_flag = 1'b1; // [R14]
        end

        // Trim status is sticky low: only a reset recovers it.
        if (evt.trim_checksum_err) begin
            s_d.flags.trim_memory_ok = 1'b0; // [R16]
        end

        // Open drain: the pin is pulled low while driven, released else.
        s_d.alert_out = 1'b0;
        s_d.alert_oe  = s_d.cfg.alert_polarity_sel
                      ? !alert_cause(s_d)
                      : alert_cause(s_d); // [R1] [R23] [R25]
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= STATE_RST; // [R16] [R20] [R21]
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        reg_rdata = s_q.rdata;
        alert_out = s_q.alert_out;
        alert_oe  = s_q.alert_oe;
    end

    always_comb begin
        alert_active = alert_cause(s_q);
    end

    default clocking cb @(posedge ref_clk);
    endclocking

    a_alert_pin_polarity: // [R1] [R25]
    assert property (disable iff (rst)
        alert_oe == (s_q.cfg.alert_polarity_sel ? !alert_active
                                                : alert_active))
    else $error("alert pin level does not match polarity and flags");

    a_energy_ovf_set: // [R2]
    assert property (disable iff (rst)
        evt.energy_ovf |=> s_q.flags.energy_overflow_flag)
    else $error("energy overflow not flagged");

    a_charge_read_clear: // [R3]
    assert property (disable iff (rst)
        evt.charge_read && !evt.charge_ovf
        |=> !s_q.flags.charge_overflow_flag)
    else $error("charge overflow flag not cleared by read");

    a_arith_flag_hold: // [R4] [R5]
    assert property (disable iff (rst)
        (s_q.flags.arith_overflow_flag || evt.arith_ovf)
        && !evt.conv_start && !evt.accumulator_clear
        |=> s_q.flags.arith_overflow_flag)
    else $error("arithmetic overflow flag lost");

    a_reserved_bit_zero: // [R6]
    assert property (disable iff (rst)
        diag_rd |=> reg_rdata[BIT_RSVD] == 1'b0
                    && reg_rdata[BIT_TRIM] == $past(s_q.flags.trim_memory_ok))
    else $error("diagnostic read data wrong");

    a_latched_limit_hold: // [R13]
    assert property (disable iff (rst)
        s_q.cfg.alert_latch_enable && s_q.flags.temp_over_limit_flag
        && !diag_rd |=> s_q.flags.temp_over_limit_flag)
    else $error("latched temperature flag dropped without a read");

    a_read_clears_latched: // [R13] [R15]
    assert property (disable iff (rst)
        s_q.cfg.alert_latch_enable && diag_rd && !sample
        && !evt.conv_done
        |=> !s_q.flags.shunt_over_limit_flag
            && !s_q.flags.power_over_limit_flag
            && !s_q.flags.conv_ready_flag)
    else $error("diagnostic read did not clear latched flags");

    a_ready_on_done: // [R14] [R23]
    assert property (disable iff (rst)
        evt.conv_done && s_q.cfg.ready_on_alert_enable
        && !reg_wr |=> s_q.flags.conv_ready_flag && alert_active)
    else $error("conversion ready not flagged on alert");

    a_trim_sticky_low: // [R16]
    assert property (disable iff (rst)
        !s_q.flags.trim_memory_ok |=> !s_q.flags.trim_memory_ok)
    else $error("trim status recovered without reset");

    a_thresholds_reset: // [R20] [R21]
    assert property (
        rst |=> s_q.shunt_over_threshold == OVTHR_RST
                && s_q.shunt_under_threshold == UVTHR_RST
                && s_q.flags.trim_memory_ok)
    else $error("threshold or trim reset value wrong");

    a_zero_shunt_trip: // [R17]
    assert property (disable iff (rst)
        sample && !s_q.cfg.alert_latch_enable
        && s_q.shunt_over_threshold[DATA_W-1] && meas.shunt == '0
        |=> s_q.flags.shunt_over_limit_flag)
    else $error("zero shunt did not trip negative over threshold");

    a_transparent_follow: // [R22] [R9]
    assert property (disable iff (rst)
        sample && !s_q.cfg.alert_latch_enable && !reg_wr
        |=> s_q.flags.shunt_under_limit_flag == $past(shunt_under))
    else $error("transparent shunt under flag does not follow compare");

    a_rdata_one_cycle: // strobed register access
    assert property (disable iff (rst)
        !reg_rd |=> reg_rdata == RDATA_NONE)
    else $error("read data present without a read");

    a_energy_read_clear: // [R2]
    assert property (disable iff (rst)
        evt.energy_read && !evt.energy_ovf
        |=> !s_q.flags.energy_overflow_flag)
    else $error("energy overflow flag not cleared by read");

    a_charge_ovf_set: // [R3]
    assert property (disable iff (rst)
        evt.charge_ovf
        |=> s_q.flags.charge_overflow_flag)
    else $error("charge overflow not flagged");

    a_arith_flag_clear: // [R5]
    assert property (disable iff (rst)
        (evt.conv_start || evt.accumulator_clear) && !evt.arith_ovf
        |=> !s_q.flags.arith_overflow_flag)
    else $error("arithmetic overflow flag not cleared");

    a_temp_over_set: // [R7]
    assert property (disable iff (rst)
        sample && temp_over
        |=> s_q.flags.temp_over_limit_flag)
    else $error("temperature over limit not flagged");

    a_bus_limits_set: // [R10] [R11]
    assert property (disable iff (rst)
        sample && (bus_over || bus_under)
        |=> (s_q.flags.bus_over_limit_flag || !$past(bus_over))
            && (s_q.flags.bus_under_limit_flag || !$past(bus_under)))
    else $error("bus limit not flagged");

    a_power_over_set: // [R12]
    assert property (disable iff (rst)
        sample && power_over
        |=> s_q.flags.power_over_limit_flag)
    else $error("power over limit not flagged");

    a_ready_start_clear: // [R15]
    assert property (disable iff (rst)
        evt.conv_start && !evt.conv_done
        |=> !s_q.flags.conv_ready_flag)
    else $error("conversion start did not clear ready flag");

    a_trim_error_drop: // [R16]
    assert property (disable iff (rst)
        evt.trim_checksum_err
        |=> !s_q.flags.trim_memory_ok)
    else $error("trim checksum error not reported");

    a_over_thr_write: // [R20]
    assert property (disable iff (rst)
        reg_wr && reg_addr == ADDR_OVTHR
        |=> s_q.shunt_over_threshold == $past(reg_wdata))
    else $error("over threshold write not stored");

endmodule // dafsl_diag

// file: verification/dafsl_host.sv
// Host model that owns the register port of the diagnostic block.
// Assumes read data stand only in the cycle after the read strobe, and a
// pull-up on the open-drain alert line.
module dafsl_host
    import dafsl_pkg::*;
(
    input  wire logic              ref_clk,
    output logic [ADDR_W-1:0]      reg_addr,
    output logic [DATA_W-1:0]      reg_wdata,
    output logic                   reg_wr,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              alert_out,
    input  wire logic              alert_oe,
    output logic                   alert_level
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // The pull-up wins whenever nobody drives the line.
    assign alert_level = alert_oe ? alert_out : 1'b1;

    // Callers keep the over threshold at or above the under one.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Callers look at the pin next, after the write has landed.
        #1;
    endtask

    // Data are taken in the one cycle where they stand.
    task automatic rd(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // dafsl_host

// file: verification/test_diag_alert_flags_and_shunt_limits.sv
// Self-checking bench of the diagnostic flag, alert and shunt limit block.
// Assumes fixed one-cycle latencies, so no wait depends on a handshake.
module test_diag_alert_flags_and_shunt_limits
    import dafsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int E_CONV = 9, E_AVG = 8, E_START = 7, E_EOVF = 6, E_COVF = 5,
        E_AOVF = 4, E_ERD = 3, E_CRD = 2, E_CLR = 1, E_TRIM = 0;
    localparam dafsl_lim_t LIM_IDLE =
        '{15'h7FFF, 15'h0000, 16'h7FFF, 16'hFFFF};

    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              alert_out;
    logic              alert_oe;
    logic              alert_level;
    dafsl_meas_t       meas = '0;
    dafsl_lim_t        lim = LIM_IDLE;
    dafsl_evt_t        evt = '0;
    int                errors = 0;
    int                n_checks = 0;

    always #20 ref_clk = ~ref_clk;

    dafsl_diag dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .meas(meas),
        .lim(lim), .evt(evt), .reg_rdata(reg_rdata), .alert_out(alert_out),
        .alert_oe(alert_oe));

    dafsl_host host (.ref_clk(ref_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .alert_out(alert_out), .alert_oe(alert_oe),
        .alert_level(alert_level));

    function automatic dafsl_evt_t evb(input int i);
        dafsl_evt_t e;
        e = '0;
        e[i] = 1'b1;
        return e;
    endfunction

    task automatic finish_test;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic exp);
        chk({15'h0000, alert_level}, {15'h0000, exp});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        rst <= 1'b1;
        meas <= '0;
        lim <= LIM_IDLE;
        evt <= '0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    task automatic ev(input int e);
        @(posedge ref_clk) evt <= evb(e);
        @(posedge ref_clk) evt <= '0;
        #1;
    endtask

    task automatic conv(input logic [19:0] sh, input logic [19:0] bs,
                        input logic [15:0] tp, input logic [23:0] pw);
        @(posedge ref_clk) meas <= '{sh, bs, tp, pw};
        ev(E_CONV);
    endtask

    task automatic t_reset;
        do_reset;
        chk_pin(1'b1);
        rd_chk(ADDR_DIAG, 16'h0001);
        rd_chk(ADDR_OVTHR, 16'h7FFF);
        rd_chk(ADDR_UVTHR, 16'h8000);
        host.wr(8'h20, 16'h1234);
        rd_chk(8'h20, 16'h0000);
        rd_chk(ADDR_OVTHR, 16'h7FFF);
        host.wr(ADDR_DIAG, 16'hF1FF);
        rd_chk(ADDR_DIAG, 16'hF001);
        $display("test reset done");
    endtask

    task automatic t_shunt;
        do_reset;
        host.wr(ADDR_OVTHR, 16'h0010);
        host.wr(ADDR_UVTHR, 16'hFFF0);
        rd_chk(ADDR_UVTHR, 16'hFFF0);
        conv(20'h00101, 20'h0, 16'h0, 24'h0);
        chk_pin(1'b0);
        rd_chk(ADDR_DIAG, 16'h0043);
        conv(20'h00100, 20'h0, 16'h0, 24'h0);
        chk_pin(1'b1);
        rd_chk(ADDR_DIAG, 16'h0003);
        conv(20'hFFEFF, 20'h0, 16'h0, 24'h0);
        rd_chk(ADDR_DIAG, 16'h0023);
        conv(20'hFFF00, 20'h0, 16'h0, 24'h0);
        rd_chk(ADDR_DIAG, 16'h0003);
        host.wr(ADDR_DIAG, 16'h1000);
        chk_pin(1'b0);
        conv(20'h00101, 20'h0, 16'h0, 24'h0);
        chk_pin(1'b1);
        host.wr(ADDR_OVTHR, 16'hFFFF);
        conv(20'h00000, 20'h0, 16'h0, 24'h0);
        rd_chk(ADDR_DIAG, 16'h1043);
        $display("test shunt done");
    endtask

    task automatic t_latch;
        do_reset;
        @(posedge ref_clk) lim <= '{15'h0020, 15'h0010, 16'h0100, 16'h0001};
        host.wr(ADDR_DIAG, 16'h8000);
        conv(20'h0, 20'h00201, 16'h0101, 24'h000101);
        conv(20'h0, 20'h00150, 16'h0000, 24'h000000);
        chk_pin(1'b0);
        rd_chk(ADDR_DIAG, 16'h8097);
        chk_pin(1'b1);
        rd_chk(ADDR_DIAG, 16'h8001);
        conv(20'h0, 20'h000FF, 16'h0000, 24'h000000);
        rd_chk(ADDR_DIAG, 16'h800B);
        $display("test latch done");
    endtask

    task automatic t_ready;
        do_reset;
        ev(E_CONV);
        chk_pin(1'b1);
        rd_chk(ADDR_DIAG, 16'h0003);
        rd_chk(ADDR_DIAG, 16'h0001);
        ev(E_CONV);
        ev(E_START);
        rd_chk(ADDR_DIAG, 16'h0001);
        host.wr(ADDR_DIAG, 16'h4000);
        ev(E_CONV);
        chk_pin(1'b0);
        rd_chk(ADDR_DIAG, 16'h4003);
        chk_pin(1'b1);
        $display("test ready done");
    endtask

    task automatic t_avg;
        logic [15:0] d;
        do_reset;
        @(posedge ref_clk) lim <= '{15'h7FFF, 15'h0000, 16'h0100, 16'hFFFF};
        host.wr(ADDR_DIAG, 16'h2000);
        conv(20'h0, 20'h0, 16'h0101, 24'h0);
        host.rd(ADDR_DIAG, d);
        chk(d & 16'h0080, 16'h0000);
        ev(E_AVG);
        host.rd(ADDR_DIAG, d);
        chk(d & 16'h0080, 16'h0080);
        $display("test averaged compare done");
    endtask

    // Arithmetic overflow is cleared once by a start and once by a clear.
    task automatic t_ovf;
        int set_i[4] = '{E_EOVF, E_COVF, E_AOVF, E_AOVF};
        int clr_i[4] = '{E_ERD, E_CRD, E_START, E_CLR};
        int bit_i[4] = '{BIT_ENOF, BIT_CHOF, BIT_ARITH, BIT_ARITH};
        logic [15:0] want;
        do_reset;
        for (int k = 0; k < 4; k++) begin
            want = 16'h0001 | (16'h0001 << bit_i[k]);
            ev(set_i[k]);
            rd_chk(ADDR_DIAG, want);
            rd_chk(ADDR_DIAG, want);
            ev(clr_i[k]);
            rd_chk(ADDR_DIAG, 16'h0001);
        end
        ev(E_TRIM);
        rd_chk(ADDR_DIAG, 16'h0000);
        $display("test overflow and trim done");
    endtask

    initial begin
        t_reset;
        t_shunt;
        t_latch;
        t_ready;
        t_avg;
        t_ovf;
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("mismatch at %0t: run did not end in time", $time);
        finish_test;
    end
endmodule // test_diag_alert_flags_and_shunt_limits
